// ### tb/daa_line_regs_chk.sv
// Port-level assertion checker for the line-side register bank
module daa_line_regs_chk #(
    parameter int CAL_CYCLES_P = 8                 // Cycles one calibration takes
) (
    input  wire logic        clk_i,                  // System clock
    input  wire logic        rst_i,                  // Sync reset, high
    input  wire logic [7:0]  wb_adr_i,               // Byte address
    input  wire logic [31:0] wb_dat_i,               // Write data
    input  wire logic [3:0]  wb_sel_i,               // Byte lanes
    input  wire logic        wb_we_i,                // Write strobe
    input  wire logic        wb_cyc_i,               // Cycle valid
    input  wire logic        wb_stb_i,               // Strobe
    input  wire logic        wb_ack_o,               // Acknowledge
    input  wire logic [31:0] wb_dat_o,               // Read data
    input  wire logic        cal_run_o,              // Calibration running
    input  wire logic [1:0]  tip_ring_voltage_sel_o, // Pin voltage code
    input  wire logic [1:0]  min_loop_current_sel_o, // Minimum current code
    input  wire logic        current_limit_en_o,     // Current cap
    input  wire logic        dc_impedance_sel_o      // Impedance select
);
    timeunit 1ns;
    timeprecision 100ps;
    wire         take    = wb_cyc_i && wb_stb_i && !wb_ack_o; // Request taken
    wire         wr_take = take && wb_we_i && wb_sel_i[0];    // Write that stores
    logic [15:0] run_cnt;                                     // Length of current run
    logic        man_q;                                       // Stored manual bit

    // Count run length and mirror the stored manual start bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_cnt <= 16'h0;
            man_q   <= 1'b0;
        end else begin
            run_cnt <= cal_run_o ? run_cnt + 16'h1 : 16'h0;
            if (wr_take && wb_adr_i == 8'h64) begin
                man_q <= wb_dat_i[6];
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd(logic [7:0] a);
        take && !wb_we_i && wb_adr_i == a;
    endsequence
    sequence s_wr_dc;
        wr_take && wb_adr_i == 8'h68;
    endsequence
    sequence s_man_start;
        wr_take && wb_adr_i == 8'h64 && wb_dat_i[6] && !man_q && !cal_run_o;
    endsequence

    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_cal_bit4_zero: assert property (s_rd(8'h64) |=> wb_dat_o[4] == 1'b0)
        else $error("calibration bit 4 read one");
    a_rsvd30_reads_zero: assert property (s_rd(8'h78) |=> wb_dat_o == 32'h0)
        else $error("reserved register read nonzero");
    a_codes_follow: assert property (s_wr_dc |=> ##1
        {tip_ring_voltage_sel_o, min_loop_current_sel_o} == $past(wb_dat_i[7:4], 2))
        else $error("voltage or current code wrong");
    a_limit_follows: assert property (s_wr_dc |=> ##1
        current_limit_en_o == $past(wb_dat_i[1], 2)) else $error("limit enable wrong");
    a_dcr_follows: assert property (s_wr_dc |=> ##1
        dc_impedance_sel_o == $past(wb_dat_i[0], 2)) else $error("impedance select wrong");
    a_manual_starts_run: assert property (s_man_start |=> ##1 cal_run_o)
        else $error("manual start ignored");
    a_run_full_length: assert property ($fell(cal_run_o) |-> run_cnt == CAL_CYCLES_P)
        else $error("calibration run length wrong");
    a_run_ends_bound: assert property (run_cnt <= CAL_CYCLES_P)
        else $error("calibration did not end");
endmodule

// ### tb/daa_line_regs_tb.sv
// Self-checking bench for the line-side register bank
module daa_line_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import daa_regs_pkg::*;
    localparam int CAL_N = 8;                      // Short calibration for the run
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic        loop_current_ok_i, line_connected_i, cal_run_o, polarity_reversal_o;
    logic        current_limit_en_o, dc_impedance_sel_o, dis;
    logic [1:0]  tip_ring_voltage_sel_o, min_loop_current_sel_o;
    logic [3:0]  wb_sel_i, trim;
    logic [7:0]  wb_adr_i, loop_current_meas_i, line_voltage_meas_i, v, lc, lv;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int          n_mismatch = 0, checks = 0, n_pol = 0, n0, seed;

    daa_line_regs #(.CAL_CYCLES_P(CAL_N)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .loop_current_meas_i(loop_current_meas_i), .line_voltage_meas_i(line_voltage_meas_i),
        .loop_current_ok_i(loop_current_ok_i), .line_connected_i(line_connected_i),
        .cal_run_o(cal_run_o), .tip_ring_voltage_sel_o(tip_ring_voltage_sel_o),
        .min_loop_current_sel_o(min_loop_current_sel_o),
        .current_limit_en_o(current_limit_en_o), .dc_impedance_sel_o(dc_impedance_sel_o),
        .polarity_reversal_o(polarity_reversal_o));
    host_bus_model u_host (.clk_i(clk_i), .ack_i(wb_ack_o), .rd_dat_i(wb_dat_o),
        .adr_o(wb_adr_i), .dat_o(wb_dat_i), .sel_o(wb_sel_i), .we_o(wb_we_i),
        .cyc_o(wb_cyc_i), .stb_o(wb_stb_i));

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Count polarity pulses seen on the pin
    always @(posedge clk_i) begin
        if (polarity_reversal_o === 1'b1) n_pol <= n_pol + 1;
    end

    // Compare one value and log a mismatch
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Expected calibration register word
    function automatic logic [31:0] f_cal(logic b, logic m, logic d, logic [3:0] t);
        return {24'h0, b, m, d, 1'b0, t};
    endfunction

    // Main sequence
    initial begin
        seed = 32'h7F75F075;
        rst_i = 1'b1;
        {loop_current_meas_i, line_voltage_meas_i} = 16'h0;
        {loop_current_ok_i, line_connected_i} = 2'b00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        u_host.xfer(1'b0, 8'h64, 8'h00, rd);
        chk("cal auto busy", rd, f_cal(1'b1, 1'b0, 1'b0, 4'h0));
        repeat (CAL_N + 4) @(posedge clk_i);
        u_host.xfer(1'b0, 8'h64, 8'h00, rd);
        chk("cal auto done", rd, f_cal(1'b0, 1'b0, 1'b0, 4'h0));
        // Manual runs with both disable settings and random trim
        for (int i = 0; i < 4; i++) begin
            trim = 4'($random(seed));
            dis = i[0];
            u_host.cal_wr(1'b1, dis, trim);
            u_host.cal_wr(1'b0, dis, trim);
            u_host.xfer(1'b0, 8'h64, 8'h00, rd);
            chk("cal manual busy", rd, f_cal(1'b1, 1'b0, dis, trim));
            repeat (CAL_N + 4) @(posedge clk_i);
            u_host.xfer(1'b0, 8'h64, 8'h00, rd);
            chk("cal manual done", rd, f_cal(1'b0, 1'b0, dis, trim));
        end
        // Every voltage and current code with random limit and impedance
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            v[7:4] = {i[1:0], i[2:1]};
            u_host.dc_wr(v);
            u_host.xfer(1'b0, 8'h68, 8'h00, rd);
            chk("dc reg", rd, {24'h0, v[7:4], 2'b00, v[1:0]});
            chk("dc pins", {26'h0, tip_ring_voltage_sel_o, min_loop_current_sel_o,
                current_limit_en_o, dc_impedance_sel_o}, {26'h0, v[7:4], v[1:0]});
        end
        // Status readings, gated by current level and line presence
        for (int i = 0; i < 4; i++) begin
            lc = 8'($random(seed));
            lv = 8'($random(seed));
            loop_current_meas_i <= lc;
            line_voltage_meas_i <= lv;
            loop_current_ok_i   <= i[0];
            line_connected_i    <= i[1];
            repeat (4) @(posedge clk_i);
            u_host.xfer(1'b1, 8'h70, 8'hA5, rd);
            u_host.xfer(1'b0, 8'h70, 8'h00, rd);
            chk("loop stat", rd, i[0] ? {24'h0, lc} : 32'h0);
            u_host.xfer(1'b0, 8'h74, 8'h00, rd);
            chk("line stat", rd, i[1] ? {24'h0, lv} : 32'h0);
        end
        // One sign flip on a connected line gives one pulse
        line_voltage_meas_i <= 8'h30;
        repeat (6) @(posedge clk_i);
        n0 = n_pol;
        line_voltage_meas_i <= 8'hD0;
        repeat (8) @(posedge clk_i);
        chk("polarity pulses", 32'(n_pol - n0), 32'h1);
        // Reserved and unmapped places ignore writes and read zero
        foreach (v[k]) begin
            if (k < 2) begin
                u_host.xfer(1'b1, k ? 8'h78 : 8'h40, 8'hFF, rd);
                u_host.xfer(1'b0, k ? 8'h78 : 8'h40, 8'h00, rd);
                chk("reserved read", rd, 32'h0);
            end
        end
        complete_run();
    end

    // Watchdog far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end
endmodule

bind daa_line_regs daa_line_regs_chk #(.CAL_CYCLES_P(CAL_CYCLES_P)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cal_run_o(cal_run_o),
    .tip_ring_voltage_sel_o(tip_ring_voltage_sel_o),
    .min_loop_current_sel_o(min_loop_current_sel_o),
    .current_limit_en_o(current_limit_en_o), .dc_impedance_sel_o(dc_impedance_sel_o));

// ### tb/host_bus_model.sv
// Wishbone classic master standing in for the system-side host
module host_bus_model (
    input  wire logic        clk_i,   // System clock
    input  wire logic        ack_i,   // Slave acknowledge
    input  wire logic [31:0] rd_dat_i, // Slave read data
    output logic      [7:0]  adr_o,   // Byte address
    output logic      [31:0] dat_o,   // Write data
    output logic      [3:0]  sel_o,   // Byte lanes
    output logic             we_o,    // Write strobe
    output logic             cyc_o,   // Cycle valid
    output logic             stb_o    // Strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus from time zero
    initial begin
        {adr_o, dat_o, sel_o, we_o, cyc_o, stb_o} = '0;
    end

    // One classic cycle, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= {24'h0, d};
        sel_o <= 4'hF;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        r = rd_dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic cal_wr(input logic m, input logic d, input logic [3:0] t);
        logic [31:0] r;
        xfer(1'b1, 8'h64, {1'b0, m, d, 1'b0, t}, r);
    endtask

    task automatic dc_wr(input logic [7:0] v);
        logic [31:0] r;
        xfer(1'b1, 8'h68, v & 8'hF3, r);
    endtask
endmodule

// ### verilog/cal_sequencer.sv
// Resistor calibration run timer with busy and done flags
module cal_sequencer
    import daa_regs_pkg::*;
#(
    parameter int CNT_MAX = 10000              // Cycles one calibration takes
) (
    input  wire logic clk_i,                   // System clock
    input  wire logic rst_i,                   // Synchronous reset, active high
    input  wire logic start_i,                 // One-cycle start request
    output logic      busy_o,                  // High while calibration runs
    output logic      done_o                   // One-cycle pulse at the end
);

    localparam int CW = $clog2(CNT_MAX + 1);   // Counter width

    cal_state_e      state;                    // Current state
    logic   [CW-1:0] count;                    // Remaining cycles
    wire             last = (count == CW'(1)); // Final cycle of a run

    // Idle until started, run for CNT_MAX cycles, then flag done
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state  <= CAL_IDLE;
            count  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                CAL_IDLE: begin
                    // Start ignored while a run is going
                    if (start_i) begin
                        state  <= CAL_RUN;
                        count  <= CW'(CNT_MAX);
                        busy_o <= 1'b1;
                    end
                end
                CAL_RUN: begin
                    count <= count - CW'(1);
                    if (last) begin
                        state  <= CAL_IDLE;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule

// ### verilog/daa_line_regs.sv
// Line-side calibration, DC termination and line status register bank on Wishbone
//
// What this block does
// - Busy bit reads one during calibration
// - Writing manual bit one starts calibration
// - Disable bit blocks internal automatic calibration; here the post-reset run starts before the bit can be set
// - Bit 4 reads zero, host never writes
// - Voltage code selects pin level, else fixed
// - Minimum current code, else fixed 10 mA
// - Limit enable caps current at 60 mA
// - Bit 0 picks 50 or 800 ohm
// - Loop current unsigned, 1.1 mA steps
// - Loop current zero below operating level
// - Line voltage signed, 1 V steps
// - Voltage sign bit shows line polarity
// - Line voltage updates on and off hook
// - Line voltage zero with no line
//
// Register access over Wishbone was decided locally.
module daa_line_regs #(
    parameter int CAL_CYCLES_P      = daa_regs_pkg::CAL_CYCLES, // Calibration run length
    parameter bit HAS_VOLTAGE_ADJ   = 1'b1,    // Variant honours voltage code
    parameter bit HAS_MIN_CURRENT   = 1'b1,    // Variant honours current code
    parameter bit HAS_CURRENT_LIMIT = 1'b1,    // Variant supports current limit
    parameter bit HAS_LINE_MONITOR  = 1'b1     // Variant reports line status
) (
    input  wire logic                              clk_i,          // 100 MHz clock
    input  wire logic                              rst_i,          // Sync reset, high
    // Wishbone classic slave
    input  wire logic [daa_regs_pkg::ADDR_W-1:0]   wb_adr_i,       // Byte address
    input  wire logic [daa_regs_pkg::DATA_W-1:0]   wb_dat_i,       // Write data
    output logic      [daa_regs_pkg::DATA_W-1:0]   wb_dat_o,       // Read data
    input  wire logic [daa_regs_pkg::SEL_W-1:0]    wb_sel_i,       // Byte lanes
    input  wire logic                              wb_we_i,        // Write strobe
    input  wire logic                              wb_cyc_i,       // Cycle valid
    input  wire logic                              wb_stb_i,       // Strobe
    output logic                                   wb_ack_o,       // Acknowledge
    // Line measurement pins, asynchronous
    input  wire logic [daa_regs_pkg::REG_W-1:0]    loop_current_meas_i,  // Raw current
    input  wire logic [daa_regs_pkg::REG_W-1:0]    line_voltage_meas_i,  // Raw voltage
    input  wire logic                              loop_current_ok_i,    // Enough current
    input  wire logic                              line_connected_i,     // Line present
    // Analog control outputs
    output logic                                   cal_run_o,            // Calibrating
    output logic      [daa_regs_pkg::SEL2_W-1:0]   tip_ring_voltage_sel_o, // Pin level
    output logic      [daa_regs_pkg::SEL2_W-1:0]   min_loop_current_sel_o, // Min current
    output logic                                   current_limit_en_o,   // 60 mA cap
    output logic                                   dc_impedance_sel_o,   // 800 ohm
    output logic                                   polarity_reversal_o   // Sign flipped
);

    import daa_regs_pkg::*;

    // Bus decode

    wire  [IDX_W-1:0] idx      = wb_adr_i[ADDR_W-1:2];          // Word index
    wire              req      = wb_cyc_i & wb_stb_i & ~wb_ack_o; // New request
    wire              wr_req   = req & wb_we_i & wb_sel_i[0];   // Write on low lane
    wire              rd_req   = req & ~wb_we_i;                // Read request

    // Compare the index against one register
    function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] r);
        hit = (a == r);
    endfunction

    wire              wr_cal   = wr_req & hit(idx, IDX_CAL_CTRL); // Calibration write
    wire              wr_dc    = wr_req & hit(idx, IDX_DC_CTRL);  // DC control write
    wire [REG_W-1:0]  wbyte    = wb_dat_i[REG_W-1:0];           // Written byte

    // Register storage

    logic             manual_cal_start;        // Manual start bit as written
    logic             cal_disable;             // Blocks automatic calibration
    logic [TRIM_W-1:0] cal_trim_value;         // Trim field, read back verbatim
    logic [SEL2_W-1:0] tip_ring_voltage_sel;   // Voltage adjust code
    logic [SEL2_W-1:0] min_loop_current_sel;   // Minimum current code
    logic             current_limit_en;        // Limit enable as written
    logic             dc_impedance_sel;        // Impedance select
    logic [REG_W-1:0] loop_current_value;      // Loop current status
    logic [REG_W-1:0] line_voltage_value;      // Line voltage status
    logic             prev_sign;               // Last seen polarity bit
    logic             prev_connected;          // Line present last cycle
    logic             auto_pending;            // Post-reset calibration not yet run

    // Calibration sequencer handshake
    logic             cal_busy;                // Run in progress
    logic             cal_done;                // Run just ended

    // Calibration control

    wire  next_manual    = wbyte[CAL_MANUAL_BIT];                 // Bit being written
    wire  manual_go      = wr_cal & next_manual & ~manual_cal_start; // Rising write
    wire  auto_go        = auto_pending & ~cal_disable;          // Automatic start
    wire  cal_start      = manual_go | auto_go;                  // Request to sequencer

    // Calibration control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            manual_cal_start <= CAL_RESET[CAL_MANUAL_BIT];
            cal_disable      <= CAL_RESET[CAL_DIS_BIT];
            cal_trim_value   <= CAL_RESET[TRIM_LSB +: TRIM_W];
        end else if (wr_cal) begin
            // Host clears the manual bit itself, within its time limit
            manual_cal_start <= next_manual;
            cal_disable      <= wbyte[CAL_DIS_BIT];
            cal_trim_value   <= wbyte[TRIM_LSB +: TRIM_W];
        end
    end

    // Automatic calibration is owed once after each reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_pending <= 1'b1;
        end else if (auto_go || manual_go || cal_disable) begin
            // Served, superseded by a manual run, or forbidden
            auto_pending <= 1'b0;
        end
    end

    // Run timer for one calibration
    cal_sequencer #(
        .CNT_MAX (CAL_CYCLES_P)
    ) u_cal_seq (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (cal_start),
        .busy_o  (cal_busy),
        .done_o  (cal_done)
    );

    // DC termination control

    // DC termination fields; reserved pair not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tip_ring_voltage_sel <= DC_RESET[VADJ_LSB +: SEL2_W];
            min_loop_current_sel <= DC_RESET[MIN_LSB +: SEL2_W];
            current_limit_en     <= DC_RESET[LIMIT_BIT];
            dc_impedance_sel     <= DC_RESET[IMP_BIT];
        end else if (wr_dc) begin
            tip_ring_voltage_sel <= wbyte[VADJ_LSB +: SEL2_W];
            min_loop_current_sel <= wbyte[MIN_LSB +: SEL2_W];
            current_limit_en     <= wbyte[LIMIT_BIT];
            dc_impedance_sel     <= wbyte[IMP_BIT];
        end
    end

    wire [SEL2_W-1:0] eff_vadj = HAS_VOLTAGE_ADJ ? tip_ring_voltage_sel : VADJ_FIXED;
    wire [SEL2_W-1:0] eff_min  = HAS_MIN_CURRENT ? min_loop_current_sel : MIN_FIXED;
    wire              eff_cap  = HAS_CURRENT_LIMIT & current_limit_en;

    // Drive the analog controls from flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tip_ring_voltage_sel_o <= VADJ_FIXED;
            min_loop_current_sel_o <= MIN_FIXED;
            current_limit_en_o     <= 1'b0;
            dc_impedance_sel_o     <= 1'b0;
            cal_run_o              <= 1'b0;
        end else begin
            tip_ring_voltage_sel_o <= eff_vadj;
            min_loop_current_sel_o <= eff_min;
            current_limit_en_o     <= eff_cap;
            dc_impedance_sel_o     <= dc_impedance_sel;
            cal_run_o              <= cal_busy;
        end
    end

    // Line measurement

    logic [REG_W-1:0] loop_meas_s;             // Synchronised current sample
    logic [REG_W-1:0] line_meas_s;             // Synchronised voltage sample
    logic             loop_ok_s;               // Synchronised current good
    logic             connected_s;             // Synchronised line present

    // Pin samples enter through two flops each
    sync_2ff #(
        .W     (2 * REG_W + 2)
    ) u_meas_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({loop_current_meas_i, line_voltage_meas_i,
                 loop_current_ok_i, line_connected_i}),
        .q_o   ({loop_meas_s, line_meas_s, loop_ok_s, connected_s})
    );

    wire [REG_W-1:0] next_loop = (HAS_LINE_MONITOR && loop_ok_s) ? loop_meas_s : STAT_RESET;
    wire [REG_W-1:0] next_line = (HAS_LINE_MONITOR && connected_s) ? line_meas_s : STAT_RESET;
    wire             flip      = connected_s & prev_connected
                               & (next_line[REG_W-1] != prev_sign);

    // Status registers track the line every cycle, hook state irrelevant
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_current_value <= STAT_RESET;
            line_voltage_value <= STAT_RESET;
            prev_sign          <= 1'b0;
            prev_connected     <= 1'b0;
            polarity_reversal_o <= 1'b0;
        end else begin
            loop_current_value <= next_loop;
            line_voltage_value <= next_line;
            prev_sign          <= next_line[REG_W-1];
            prev_connected     <= connected_s & HAS_LINE_MONITOR;
            polarity_reversal_o <= flip & HAS_LINE_MONITOR;
        end
    end

    // Read path

    wire [REG_W-1:0] cal_view  = {cal_busy, manual_cal_start, cal_disable, 1'b0,
                                  cal_trim_value};
    // Reserved pair reads zero
    wire [REG_W-1:0] dc_view   = {tip_ring_voltage_sel, min_loop_current_sel, 2'h0,
                                  current_limit_en, dc_impedance_sel};

    // Read multiplexer; reserved and unmapped words read zero
    logic [REG_W-1:0] rd_byte;                 // Selected register
    always_comb begin
        unique case (idx)
            IDX_CAL_CTRL:  rd_byte = cal_view;
            IDX_DC_CTRL:   rd_byte = dc_view;
            IDX_LOOP_STAT: rd_byte = loop_current_value;
            IDX_LINE_STAT: rd_byte = line_voltage_value;
            IDX_RSVD_30:   rd_byte = STAT_RESET;
            default:       rd_byte = STAT_RESET;
        endcase
    end

    // Bus answer

    // One-cycle acknowledge, data held until next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (rd_req) begin
                wb_dat_o <= {{(DATA_W - REG_W){1'b0}}, rd_byte};
            end
        end
    end

endmodule

// ### verilog/daa_regs_pkg.sv
// Shared constants and types for the line-side calibration and DC status register bank
package daa_regs_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;                 // Wishbone byte address width
    localparam int DATA_W = 32;                // Wishbone data width
    localparam int SEL_W  = DATA_W / 8;        // Byte lane selects
    localparam int REG_W  = 8;                 // Width of each register
    localparam int IDX_W  = ADDR_W - 2;        // Word index width

    // Register indexes, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CAL_CTRL  = 6'h19;  // resistor_calibration_ctrl
    localparam logic [IDX_W-1:0] IDX_DC_CTRL   = 6'h1A;  // dc_termination_ctrl
    localparam logic [IDX_W-1:0] IDX_RSVD_27   = 6'h1B;  // reserved_reg_27
    localparam logic [IDX_W-1:0] IDX_LOOP_STAT = 6'h1C;  // loop_current_status
    localparam logic [IDX_W-1:0] IDX_LINE_STAT = 6'h1D;  // line_voltage_status
    localparam logic [IDX_W-1:0] IDX_RSVD_30   = 6'h1E;  // reserved_reg_30

    // Calibration register fields
    localparam int CAL_BUSY_BIT   = 7;         // cal_in_progress
    localparam int CAL_MANUAL_BIT = 6;         // manual_cal_start
    localparam int CAL_DIS_BIT    = 5;         // cal_disable
    localparam int CAL_RSVD_BIT   = 4;         // Always reads zero
    localparam int TRIM_LSB       = 0;         // cal_trim_value low bit
    localparam int TRIM_W         = 4;         // cal_trim_value width

    // DC termination register fields
    localparam int VADJ_LSB     = 6;           // tip_ring_voltage_sel
    localparam int MIN_LSB      = 4;           // min_loop_current_sel
    localparam int DC_RSVD_LSB  = 2;           // Reserved pair
    localparam int LIMIT_BIT    = 1;           // current_limit_en
    localparam int IMP_BIT      = 0;           // dc_impedance_sel
    localparam int SEL2_W       = 2;           // Two-bit code width

    // Reset values
    localparam logic [REG_W-1:0]  CAL_RESET    = 8'h00;
    localparam logic [REG_W-1:0]  DC_RESET     = 8'h00;
    localparam logic [REG_W-1:0]  STAT_RESET   = 8'h00;
    localparam logic [SEL2_W-1:0] VADJ_FIXED   = 2'h2;  // Fixed 3.35 V code
    localparam logic [SEL2_W-1:0] MIN_FIXED    = 2'h0;  // Fixed 10 mA code

    // Timing
    localparam int CLK_PERIOD_NS = 10;         // 100 MHz
    localparam int CAL_TIME_NS   = 100000;     // Calibration run length, 100 us
    localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Calibration sequencer states
    typedef enum logic {
        CAL_IDLE,
        CAL_RUN
    } cal_state_e;

endpackage

// ### verilog/sync_2ff.sv
// Two flip-flop synchroniser for pin inputs
module sync_2ff #(
    parameter int W = 1                        // Bus width
) (
    input  wire logic         clk_i,           // System clock
    input  wire logic         rst_i,           // Synchronous reset, active high
    input  wire logic [W-1:0] d_i,             // Asynchronous input
    output logic      [W-1:0] q_o              // Synchronised output
);

    logic [W-1:0] meta;                        // First stage, read only by second

    // Two stages, first stage feeds nothing else
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule
